// ### rtl/video_ram_physical_access.v
`timescale 1ns/1ps
`include "vram_access_map.vh"
module video_ram_physical_access #(
  parameter AW = 23,
  parameter DW = 32,
  parameter LVW = 9,
  parameter CNTW = 9,
  parameter BUF_DEPTH = 2
) (
  // clock and reset
  input wire clock,
  input wire rst_n,
  // configuration
  input wire mappingEnableFlag,
  input wire bankInterleave,
  input wire layerSourceSelect,
  input wire [3:0] layerNumberRegister,
  input wire [31:0] coordMinRegister,
  input wire [31:0] coordMaxRegister,
  input wire [1:0] directPriority,
  input wire [1:0] indirectPriority,
  input wire [LVW-1:0] inputFifoMaxThreshold,
  input wire [LVW-1:0] inputFifoMinThreshold,
  input wire [LVW-1:0] outputFifoMaxThreshold,
  input wire [LVW-1:0] outputFifoMinThreshold,
  // two host windows
  input wire [31:0] chipSelectRegionBase,
  input wire [31:0] windowHostOffset0,
  input wire [31:0] windowSize0,
  input wire [31:0] windowVramBase0,
  input wire [31:0] windowHostOffset1,
  input wire [31:0] windowSize1,
  input wire [31:0] windowVramBase1,
  // host direct mapped access
  input wire hostReq,
  input wire hostWrite,
  input wire [31:0] hostAddr,
  input wire [DW-1:0] hostWdata,
  output reg hostAck_r,
  output reg [DW-1:0] hostRdata_r,
  output reg hostRdataOe_n_r,
  output reg directAccessReady_r,
  // command port
  input wire cmdValid,
  input wire [1:0] cmdOp,
  input wire [CNTW-1:0] cmdCount,
  output reg cmdReady_r,
  // input fifo
  input wire inValid,
  input wire [31:0] inData,
  input wire [LVW-1:0] inLevel,
  output reg inReady_r,
  // output fifo
  output wire outValid,
  output wire [DW-1:0] outData,
  input wire outReady,
  input wire [LVW-1:0] outLevel,
  // layer description lookup
  output reg [3:0] pixLayer_r,
  input wire [2:0] layerShift,
  input wire [13:0] layerDomSizeX,
  input wire [AW-1:0] layerBase,
  // translated pixel address to drawing engine
  output reg pixValid_r,
  output reg [AW-1:0] pixAddr_r,
  input wire pixReady,
  // memory arbiter request
  output reg memReq_r,
  output reg memWrite_r,
  output reg [AW-1:0] memAddr_r,
  output reg [DW-1:0] memWdata_r,
  output reg [1:0] memPriority_r,
  output reg memRealTime_r,
  output reg memRowHit_r,
  input wire memGnt,
  input wire memRvalid,
  input wire [DW-1:0] memRdata
);
  // ==========================================
  // states
  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_DIR = 4'h1;
  localparam [3:0] S_DRD = 4'h2;
  localparam [3:0] S_PADR = 4'h3;
  localparam [3:0] S_PUT = 4'h4;
  localparam [3:0] S_GET = 4'h5;
  localparam [3:0] S_PIXW = 4'h6;
  localparam [3:0] S_PIXL = 4'h7;
  localparam [3:0] S_PIXT = 4'h8;

  reg [3:0] state_r;
  reg [1:0] op_r;
  reg [CNTW-1:0] remain_r;
  reg [LVW-1:0] blockLeft_r;
  reg readOut_r;
  reg [13:0] pixX_r;
  reg [13:0] pixY_r;
  reg [AW-1:10] openRow_r;
  reg openValid_r;

  // ==========================================
  // output buffer: a stalled receiver backs up into the get burst
  wire bufInReady;
  wire bufPush;
  assign bufPush = memRvalid && (state_r == S_GET);

  vram_out_buffer #(
    .WIDTH(DW),
    .DEPTH(BUF_DEPTH),
    .PW(1)
  ) outBuf (
    .clock(clock),
    .rst_n(rst_n),
    .inValid(bufPush),
    .inData(memRdata),
    .inReady(bufInReady),
    .outValid(outValid),
    .outData(outData),
    .outReady(outReady)
  );

  // ==========================================
  // window decode
  wire [31:0] csOffset;
  wire [31:0] vAddr0;
  wire [31:0] vAddr1;
  wire hit0;
  wire hit1;
  wire winHit;
  wire [AW-1:0] winAddr;
  assign csOffset = hostAddr - chipSelectRegionBase;
  assign vAddr0 = csOffset - windowHostOffset0 + windowVramBase0;
  assign vAddr1 = csOffset - windowHostOffset1 + windowVramBase1;
  assign hit0 = (vAddr0 >= windowVramBase0) &&
    (vAddr0 < windowVramBase0 + windowSize0);
  assign hit1 = (vAddr1 >= windowVramBase1) &&
    (vAddr1 < windowVramBase1 + windowSize1);
  // window 0 wins where both overlap
  assign winHit = mappingEnableFlag && (hit0 || hit1);
  assign winAddr = hit0 ? vAddr0[AW-1:0] : vAddr1[AW-1:0];

  // ==========================================
  // pixel to physical translation
  reg [18:0] xShift;
  reg [18:0] xBits;
  reg [10:0] xRows;
  reg [20:0] rowAddr;
  reg [7:0] colAddr;
  reg [AW-1:0] physRel;
  always @* begin
    xShift = {5'h00, pixX_r} << layerShift;
    xBits = {5'h00, layerDomSizeX} << layerShift;
    colAddr = {pixY_r[4:0], xShift[7:5]};
    if (bankInterleave) begin
      xRows = {1'b0, xBits[18:9]} + {10'h000, |xBits[8:0]};
      rowAddr = {13'h0000, pixY_r[13:6]} * {10'h000, xRows} +
        {11'h000, xShift[18:9]};
      // row, then bank {y5, x8}, then column, then byte bits
      physRel = {rowAddr[10:0], pixY_r[5], xShift[8], colAddr,
        2'h0};
    end else begin
      xRows = xBits[18:8] + {10'h000, |xBits[7:0]};
      rowAddr = {12'h000, pixY_r[13:5]} * {10'h000, xRows} +
        {10'h000, xShift[18:8]};
      physRel = {rowAddr[12:0], colAddr, 2'h0};
    end
  end

  // ==========================================
  // next-request helpers
  wire [AW-1:10] reqRow;
  wire hostPending;
  wire preferHost;
  wire [LVW-1:0] remainLv;
  wire [LVW-1:0] inBlock;
  wire [LVW-1:0] outBlock;
  wire inStart;
  wire outStart;
  assign hostPending = hostReq && !hostAck_r;
  assign preferHost = directPriority >= indirectPriority;
  assign remainLv = remain_r[LVW-1:0];
  assign inBlock = (inputFifoMinThreshold == {LVW{1'b0}}) ?
    {{(LVW-1){1'b0}}, 1'b1} :
    (remainLv < inputFifoMinThreshold) ? remainLv :
    inputFifoMinThreshold;
  assign outBlock = (outputFifoMinThreshold == {LVW{1'b0}}) ?
    {{(LVW-1){1'b0}}, 1'b1} :
    (remainLv < outputFifoMinThreshold) ? remainLv :
    outputFifoMinThreshold;
  // put starts when fifo reached max or already holds the rest
  assign inStart = (inLevel >= inputFifoMaxThreshold) ||
    (inLevel >= remainLv);
  // a get block starts only while output fifo sits below max
  assign outStart = outLevel < outputFifoMaxThreshold;
  assign reqRow = memAddr_r[AW-1:10];

  // ==========================================
  // main sequencer
  always @(posedge clock) begin
    if (!rst_n) begin
      state_r <= S_IDLE;
      op_r <= `OP_PUT;
      remain_r <= {CNTW{1'b0}};
      blockLeft_r <= {LVW{1'b0}};
      readOut_r <= 1'b0;
      pixX_r <= 14'h0000;
      pixY_r <= 14'h0000;
      openRow_r <= {(AW-10){1'b0}};
      openValid_r <= 1'b0;
      hostAck_r <= 1'b0;
      hostRdata_r <= {DW{1'b0}};
      hostRdataOe_n_r <= 1'b1;
      directAccessReady_r <= 1'b1;
      cmdReady_r <= 1'b0;
      inReady_r <= 1'b0;
      pixLayer_r <= 4'h0;
      pixValid_r <= 1'b0;
      pixAddr_r <= {AW{1'b0}};
      memReq_r <= 1'b0;
      memWrite_r <= 1'b0;
      memAddr_r <= {AW{1'b0}};
      memWdata_r <= {DW{1'b0}};
      memPriority_r <= 2'h0;
      memRealTime_r <= 1'b0;
      memRowHit_r <= 1'b0;
    end else begin
      hostAck_r <= 1'b0;
      hostRdataOe_n_r <= 1'b1;
      cmdReady_r <= 1'b0;
      if (memReq_r && memGnt) begin
        memReq_r <= 1'b0;
        openRow_r <= reqRow;
        openValid_r <= 1'b1;
      end
      case (state_r)
        S_IDLE: begin
          directAccessReady_r <= 1'b1;
          if (hostPending && (preferHost || !cmdValid)) begin
            if (!winHit) begin
              // refused: write dropped, read answered undriven
              hostAck_r <= 1'b1;
            end else begin
              // one plain arbiter request, no posting
              memReq_r <= 1'b1;
              memWrite_r <= hostWrite;
              memAddr_r <= winAddr;
              memWdata_r <= hostWdata;
              memPriority_r <= directPriority;
              memRealTime_r <= directPriority >= `RT_PRIO_MIN;
              memRowHit_r <= openValid_r &&
                (winAddr[AW-1:10] == openRow_r);
              directAccessReady_r <= 1'b0;
              state_r <= S_DIR;
            end
          end else if (cmdValid) begin
            cmdReady_r <= 1'b1;
            op_r <= cmdOp;
            remain_r <= cmdCount;
            memPriority_r <= indirectPriority;
            memRealTime_r <= indirectPriority >= `RT_PRIO_MIN;
            if (cmdOp == `OP_PIXREG) begin
              // coordinates from registers, fifo untouched
              pixX_r <= coordMinRegister[`LA_X_MSB:`LA_X_LSB];
              pixY_r <= coordMinRegister[`LA_Y_MSB:`LA_Y_LSB];
              pixLayer_r <= layerNumberRegister;
              remain_r <= {{(CNTW-2){1'b0}}, 2'h2};
              state_r <= S_PIXL;
            end else if (cmdOp == `OP_PIXFIFO) begin
              state_r <= (cmdCount == {CNTW{1'b0}}) ? S_IDLE : S_PIXW;
            end else begin
              state_r <= S_PADR;
            end
          end
        end
        S_DIR: begin
          if (memReq_r && memGnt) begin
            if (memWrite_r) begin
              hostAck_r <= 1'b1;
              state_r <= S_IDLE;
            end else begin
              state_r <= S_DRD;
            end
          end
        end
        S_DRD: begin
          if (memRvalid) begin
            hostRdata_r <= memRdata;
            hostRdataOe_n_r <= 1'b0;
            hostAck_r <= 1'b1;
            state_r <= S_IDLE;
          end
        end
        S_PADR: begin
          // start address comes in through the input fifo
          if (inValid && inReady_r) begin
            inReady_r <= 1'b0;
            memAddr_r <= inData[AW-1:0];
            blockLeft_r <= {LVW{1'b0}};
            readOut_r <= 1'b0;
            if (remain_r == {CNTW{1'b0}}) begin
              state_r <= S_IDLE;
            end else begin
              state_r <= (op_r == `OP_GET) ? S_GET : S_PUT;
            end
          end else begin
            inReady_r <= 1'b1;
          end
        end
        S_PUT: begin
          if (memReq_r) begin
            if (memGnt) begin
              memAddr_r <= memAddr_r + `WORD_STEP;
              remain_r <= remain_r - 1'b1;
              blockLeft_r <= blockLeft_r - 1'b1;
              if (remain_r == 1) begin
                state_r <= S_IDLE;
              end
            end
          end else if (blockLeft_r == {LVW{1'b0}}) begin
            if (inStart) begin
              blockLeft_r <= inBlock;
            end
          end else if (inValid && inReady_r) begin
            inReady_r <= 1'b0;
            memReq_r <= 1'b1;
            memWrite_r <= 1'b1;
            memWdata_r <= inData[DW-1:0];
            memRowHit_r <= openValid_r && (reqRow == openRow_r);
          end else begin
            inReady_r <= 1'b1;
          end
        end
        S_GET: begin
          if (memRvalid) begin
            readOut_r <= 1'b0;
            if (remain_r == {CNTW{1'b0}}) begin
              state_r <= S_IDLE;
            end
          end
          if (memReq_r) begin
            if (memGnt) begin
              memAddr_r <= memAddr_r + `WORD_STEP;
              remain_r <= remain_r - 1'b1;
              blockLeft_r <= blockLeft_r - 1'b1;
            end
          end else if (remain_r != {CNTW{1'b0}} && !readOut_r &&
              !memRvalid) begin
            if (blockLeft_r == {LVW{1'b0}}) begin
              if (outStart) begin
                blockLeft_r <= outBlock;
              end
            end else if (bufInReady) begin
              // one read in flight, so the buffer always has room
              memReq_r <= 1'b1;
              memWrite_r <= 1'b0;
              readOut_r <= 1'b1;
              memRowHit_r <= openValid_r && (reqRow == openRow_r);
            end
          end
        end
        S_PIXW: begin
          if (inValid && inReady_r) begin
            inReady_r <= 1'b0;
            pixX_r <= inData[`LA_X_MSB:`LA_X_LSB];
            pixY_r <= inData[`LA_Y_MSB:`LA_Y_LSB];
            if (layerSourceSelect) begin
              pixLayer_r <= layerNumberRegister;
            end else begin
              pixLayer_r <= {inData[`LA_LHI_MSB:`LA_LHI_LSB],
                inData[`LA_LLO_MSB:`LA_LLO_LSB]};
            end
            state_r <= S_PIXL;
          end else begin
            inReady_r <= 1'b1;
          end
        end
        S_PIXL: begin
          // one cycle for the layer table to answer
          state_r <= S_PIXT;
        end
        S_PIXT: begin
          if (!pixValid_r) begin
            pixValid_r <= 1'b1;
            pixAddr_r <= layerBase + physRel;
          end else if (pixReady) begin
            pixValid_r <= 1'b0;
            remain_r <= remain_r - 1'b1;
            if (remain_r == 1) begin
              state_r <= S_IDLE;
            end else if (op_r == `OP_PIXREG) begin
              pixX_r <= coordMaxRegister[`LA_X_MSB:`LA_X_LSB];
              pixY_r <= coordMaxRegister[`LA_Y_MSB:`LA_Y_LSB];
              state_r <= S_PIXL;
            end else begin
              state_r <= S_PIXW;
            end
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end
endmodule

// ### rtl/vram_access_map.vh
`ifndef VRAM_ACCESS_MAP_VH
`define VRAM_ACCESS_MAP_VH
// ==========================================
// block geometry
`define COLS_PER_ROW 256
`define BLOCK_WORDS 8
`define BLOCK_LINES 32
`define BANK_COUNT 4
`define BYTE_BITS 2
`define WORD_STEP 23'h000004
// ==========================================
// logical pixel address word
`define LA_LHI_MSB 31
`define LA_LHI_LSB 30
`define LA_X_MSB 29
`define LA_X_LSB 16
`define LA_LLO_MSB 15
`define LA_LLO_LSB 14
`define LA_Y_MSB 13
`define LA_Y_LSB 0
// ==========================================
// command codes
`define OP_PUT 2'h0
`define OP_GET 2'h1
`define OP_PIXFIFO 2'h2
`define OP_PIXREG 2'h3
// ==========================================
// real-time priority threshold
`define RT_PRIO_MIN 2'h2
`endif

// ### rtl/vram_out_buffer.v
`timescale 1ns/1ps
module vram_out_buffer #(
  parameter WIDTH = 32,
  parameter DEPTH = 2,
  parameter PW = 1
) (
  // clock and reset
  input wire clock,
  input wire rst_n,
  // fill side
  input wire inValid,
  input wire [WIDTH-1:0] inData,
  output wire inReady,
  // drain side
  output wire outValid,
  output wire [WIDTH-1:0] outData,
  input wire outReady
);
  // ==========================================
  // storage
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [PW-1:0] wrPtr_r;
  reg [PW-1:0] rdPtr_r;
  reg [PW:0] count_r;
  wire push;
  wire pop;

  assign inReady = (count_r != DEPTH[PW:0]);
  assign outValid = (count_r != {(PW+1){1'b0}});
  assign outData = mem[rdPtr_r];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  // pointers wrap at depth, so depth need not be a power of two
  always @(posedge clock) begin
    if (!rst_n) begin
      wrPtr_r <= {PW{1'b0}};
      rdPtr_r <= {PW{1'b0}};
      count_r <= {(PW+1){1'b0}};
    end else begin
      if (push) begin
        wrPtr_r <= (wrPtr_r == DEPTH[PW-1:0] - 1'b1) ? {PW{1'b0}} :
          wrPtr_r + 1'b1;
      end
      if (pop) begin
        rdPtr_r <= (rdPtr_r == DEPTH[PW-1:0] - 1'b1) ? {PW{1'b0}} :
          rdPtr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

  always @(posedge clock) begin
    if (push) begin
      mem[wrPtr_r] <= inData;
    end
  end
endmodule

// ### verif/sdram_arbiter_model.sv
`timescale 1ns/1ps
// ====================================
// arbiter and video ram stand-in
module sdram_arbiter_model #(
  parameter AW = 23
) (
  // clock and reset
  input logic clock,
  input logic rst_n,
  // stall control
  input logic slow,
  // request side
  input logic memReq,
  input logic memWrite,
  input logic [AW-1:0] memAddr,
  input logic [31:0] memWdata,
  output logic memGnt,
  output logic memRvalid,
  output logic [31:0] memRdata
);
  logic [31:0] mem [logic [AW-1:0]];
  logic [31:0] rdWord;
  logic [31:0] junk;
  logic [1:0] rdPipe;
  int waitCnt;
  // idle bus churns so a stale word never looks valid
  assign memRvalid = rdPipe[1];
  assign memRdata = memRvalid ? rdWord : junk;
  always @(posedge clock) begin
    memGnt <= 1'b0;
    rdPipe <= {rdPipe[0], 1'b0};
    junk <= {junk[30:0], ~junk[31]};
    if (!rst_n) begin
      waitCnt <= 0;
      rdPipe <= 2'h0;
      junk <= 32'h0;
    end else if (memReq && !memGnt) begin
      // with slow set, each request waits five cycles behind other jobs; otherwise it is granted at once
      if (waitCnt >= (slow ? 5 : 0)) begin
        memGnt <= 1'b1;
        waitCnt <= 0;
        if (memWrite) mem[memAddr] = memWdata;
        else begin
          rdWord <= mem.exists(memAddr) ? mem[memAddr] : 32'h0;
          rdPipe[0] <= 1'b1;
        end
      end else waitCnt <= waitCnt + 1;
    end
  end
endmodule

// ### verif/video_ram_physical_access_tb.sv
`timescale 1ns/1ps
module video_ram_physical_access_tb;
  // ====================================
  // stimulus and observed ports
  logic clock = 1'b0, rst_n = 1'b0, slow = 1'b0;
  logic mappingEnableFlag = 1'b0, bankInterleave = 1'b0;
  logic layerSourceSelect = 1'b0, hostReq = 1'b0, hostWrite = 1'b0;
  logic cmdValid = 1'b0, inValid = 1'b0, outReady = 1'b0, pixReady = 1'b0;
  logic [3:0] layerNumberRegister = 4'h5;
  logic [31:0] coordMinRegister = 32'h0, coordMaxRegister = 32'h0;
  logic [31:0] hostAddr = 32'h0, hostWdata = 32'h0, inData = 32'h0;
  logic [1:0] cmdOp = 2'h0, prio = 2'h2;
  logic [8:0] cmdCount = 9'h0, thr = 9'h004, inLevel = 9'h010;
  logic [8:0] outLevel = 9'h000;
  logic hostAck_r, hostRdataOe_n_r, directAccessReady_r, cmdReady_r;
  logic inReady_r, outValid, pixValid_r, memReq_r, memWrite_r, memGnt;
  logic memRealTime_r, memRowHit_r, memRvalid;
  logic [31:0] hostRdata_r, outData, memWdata_r, memRdata, seed = 32'h1b;
  logic [22:0] pixAddr_r, memAddr_r, layerBase, lastMa;
  logic [3:0] pixLayer_r;
  logic [1:0] memPriority_r;
  logic [2:0] layerShift;
  logic [13:0] layerDomSizeX;
  logic [31:0] cs = 32'h40000000, off [2] = '{32'h00100000, 32'h00200000};
  logic [31:0] sz [2] = '{32'h1000, 32'h800}, vb [2] = '{32'h0, 32'h10000};
  int n_fail = 0, n_checks = 0, cyc = 0;
  // layer table stand-in: depth and width follow the layer number
  assign layerShift = {1'b0, pixLayer_r[1:0]};
  assign layerDomSizeX = 14'h0064 + {10'h0, pixLayer_r};
  assign layerBase = {pixLayer_r, 19'h0};
  always #2 clock = ~clock;
  video_ram_physical_access DUT (.clock, .rst_n, .mappingEnableFlag,
    .bankInterleave, .layerSourceSelect, .layerNumberRegister,
    .coordMinRegister, .coordMaxRegister, .directPriority(prio),
    .indirectPriority(prio), .inputFifoMaxThreshold(thr),
    .inputFifoMinThreshold(thr), .outputFifoMaxThreshold(thr),
    .outputFifoMinThreshold(thr), .chipSelectRegionBase(cs),
    .windowHostOffset0(off[0]), .windowSize0(sz[0]),
    .windowVramBase0(vb[0]), .windowHostOffset1(off[1]),
    .windowSize1(sz[1]), .windowVramBase1(vb[1]), .hostReq, .hostWrite,
    .hostAddr, .hostWdata, .hostAck_r, .hostRdata_r, .hostRdataOe_n_r,
    .directAccessReady_r, .cmdValid, .cmdOp, .cmdCount, .cmdReady_r,
    .inValid, .inData, .inLevel, .inReady_r, .outValid, .outData,
    .outReady, .outLevel, .pixLayer_r, .layerShift, .layerDomSizeX,
    .layerBase, .pixValid_r, .pixAddr_r, .pixReady, .memReq_r,
    .memWrite_r, .memAddr_r, .memWdata_r, .memPriority_r, .memRealTime_r,
    .memRowHit_r, .memGnt, .memRvalid, .memRdata);
  sdram_arbiter_model far (.clock, .rst_n, .slow, .memReq(memReq_r),
    .memWrite(memWrite_r), .memAddr(memAddr_r), .memWdata(memWdata_r),
    .memGnt, .memRvalid, .memRdata);
  // ====================================
  // helpers
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  function automatic logic [22:0] pa(input logic [3:0] l,
      input logic [13:0] x, input logic [13:0] y);
    logic [18:0] xb, xs;
    logic [22:0] ra, xr;
    xb = {5'h0, 14'h0064 + {10'h0, l}} << l[1:0];
    xs = {5'h0, x} << l[1:0];
    if (bankInterleave) begin
      xr = xb[18:9] + (|xb[8:0]);
      ra = y[13:6] * xr + xs[18:9];
      return {l, 19'h0} + (ra << 12) + ({y[5], xs[8]} << 10)
        + ({y[4:0], xs[7:5]} << 2);
    end
    xr = xb[18:8] + (|xb[7:0]);
    ra = y[13:5] * xr + xs[18:8];
    return {l, 19'h0} + (ra << 10) + ({y[4:0], xs[7:5]} << 2);
  endfunction
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // values read right after the edge are what the design sampled
  task automatic waitHi(ref logic s);
    int k;
    k = 0;
    do begin
      @(posedge clock);
      k++;
      if (memReq_r) lastMa = memAddr_r;
    end while (s !== 1'b1 && k < 300);
    if (s !== 1'b1) begin
      n_fail++;
      $display("Error at %0t: expected %h got %h", $time, 1'b1, s);
    end
  endtask
  task automatic host(input logic w, input logic [31:0] a, input
      logic [31:0] d, output logic [31:0] rd, output logic oe);
    if (w) waitHi(directAccessReady_r);
    lastMa = 23'h7fffff;
    @(negedge clock);
    hostReq = 1'b1;
    hostWrite = w;
    hostAddr = a;
    hostWdata = d;
    waitHi(hostAck_r);
    rd = hostRdata_r;
    oe = hostRdataOe_n_r;
    @(negedge clock);
    hostReq = 1'b0;
  endtask
  task automatic cmd(input logic [1:0] op, input logic [8:0] n);
    @(negedge clock);
    cmdValid = 1'b1;
    cmdOp = op;
    cmdCount = n;
    waitHi(cmdReady_r);
    @(negedge clock);
    cmdValid = 1'b0;
  endtask
  task automatic push(input logic [31:0] w);
    @(negedge clock);
    inValid = 1'b1;
    inData = w;
    waitHi(inReady_r);
    @(negedge clock);
    inValid = 1'b0;
  endtask
  task automatic pop(output logic [31:0] d);
    @(negedge clock);
    outReady = 1'b1;
    waitHi(outValid);
    d = outData;
    @(negedge clock);
    outReady = 1'b0;
  endtask
  task automatic pix(output logic [3:0] l, output logic [22:0] a);
    repeat (rnd() % 4) @(negedge clock);
    pixReady = 1'b1;
    waitHi(pixValid_r);
    l = pixLayer_r;
    a = pixAddr_r;
    @(negedge clock);
    pixReady = 1'b0;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      end_sim();
    end
  end
  // ====================================
  // scenarios
  initial begin
    logic [31:0] a, d, o, rd, q [6];
    logic oe;
    logic [3:0] l, lq;
    logic [22:0] e;
    logic [13:0] x, y;
    int w;
    repeat (16) @(negedge clock);
    rst_n = 1'b1;
    mappingEnableFlag = 1'b1;
    // both windows, first word of window 0 and last of window 1 among random ones
    for (int i = 0; i < 8; i++) begin
      w = i & 1;
      o = i == 0 ? 32'h0 : i == 1 ? sz[1] - 32'h4 : rnd() & (sz[w] - 32'h4);
      a = cs + off[w] + o;
      d = rnd();
      prio = rnd();
      host(1'b1, a, d, rd, oe);
      chk(vb[w] + o, {9'h0, lastMa});
      host(1'b0, a, 32'h0, rd, oe);
      chk(d, rd);
      chk(32'h0, oe);
    end
    // just past each window, then a good address with mapping off
    for (int i = 0; i < 3; i++) begin
      mappingEnableFlag = i < 2;
      a = cs + off[i & 1] + (i < 2 ? sz[i & 1] : 32'h0);
      host(1'b1, a, 32'h0, rd, oe);
      chk(32'h7fffff, {9'h0, lastMa});
      host(1'b0, a, 32'h0, rd, oe);
      chk(32'h7fffff, {9'h0, lastMa});
      chk(32'h1, oe);
    end
    mappingEnableFlag = 1'b1;
    // segment aligned on the block grid, slow memory, reader stalls
    slow = 1'b1;
    for (int k = 0; k < 6; k++) q[k] = rnd();
    cmd(2'h0, 9'h006);
    push(32'h3e0);
    for (int k = 0; k < 6; k++) push(q[k]);
    cmd(2'h1, 9'h006);
    push(32'h3e0);
    repeat (12) @(negedge clock);
    for (int k = 0; k < 6; k++) begin
      repeat (rnd() % 3) @(negedge clock);
      pop(d);
      chk(q[k], d);
    end
    host(1'b0, cs + off[0] + 32'h3f4, 32'h0, rd, oe);
    chk(q[5], rd);
    slow = 1'b0;
    // pixel words: both layer sources, both bank layouts
    for (int m = 0; m < 4; m++) begin
      bankInterleave = m[0];
      layerSourceSelect = m[1];
      l = rnd();
      x = rnd() & 14'h00ff;
      y = rnd() & 14'h01ff;
      cmd(2'h2, 9'h001);
      push({l[3:2], x, l[1:0], y});
      pix(lq, e);
      l = layerSourceSelect ? layerNumberRegister : l;
      chk(l, lq);
      chk(pa(l, x, y), e);
    end
    // corners from registers, nothing from the input fifo
    coordMinRegister = {2'h0, x, 2'h0, y};
    coordMaxRegister = {2'h0, x + 14'h7, 2'h0, y + 14'h21};
    cmd(2'h3, 9'h001);
    pix(lq, e);
    chk(pa(layerNumberRegister, x, y), e);
    pix(lq, e);
    chk(pa(layerNumberRegister, x + 14'h7, y + 14'h21), e);
    end_sim();
  end
endmodule

// ### verif/vram_access_chk.sv
`timescale 1ns/1ps
// ====================================
// port checker
module vram_access_chk #(
  parameter AW = 23,
  parameter DW = 32
) (
  // clock and reset
  input wire clock,
  input wire rst_n,
  // host side
  input wire mappingEnableFlag,
  input wire hostReq,
  input wire hostWrite,
  input wire hostAck_r,
  input wire hostRdataOe_n_r,
  input wire directAccessReady_r,
  // commands and streams
  input wire cmdReady_r,
  input wire inValid,
  input wire inReady_r,
  input wire outValid,
  input wire [DW-1:0] outData,
  input wire outReady,
  input wire pixValid_r,
  input wire [AW-1:0] pixAddr_r,
  input wire pixReady,
  // memory side
  input wire memReq_r,
  input wire memWrite_r,
  input wire [AW-1:0] memAddr_r,
  input wire [1:0] memPriority_r,
  input wire memRealTime_r,
  input wire memRowHit_r,
  input wire memGnt
);
  logic [AW-1:10] lastRow;
  logic lastOk;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // row of the last granted request, for the open-row flag
  always @(posedge clock) begin
    if (!rst_n) begin
      lastOk <= 1'b0;
    end else if (memReq_r && memGnt) begin
      lastOk <= 1'b1;
      lastRow <= memAddr_r[AW-1:10];
    end
  end
  row_hit_a: assert property ($rose(memReq_r) |->
    memRowHit_r == (lastOk && memAddr_r[AW-1:10] == lastRow))
    else $error("open row flag wrong");
  ready_busy_a: assert property (hostAck_r && !hostRdataOe_n_r |->
    !directAccessReady_r)
    else $error("direct ready high during a direct read");
  ack_cause_a: assert property (hostAck_r |-> $past(hostReq))
    else $error("host ack without request");
  ack_pulse_a: assert property (hostAck_r |=> !hostAck_r)
    else $error("host ack longer than one cycle");
  read_drive_a: assert property (!hostRdataOe_n_r |->
    hostAck_r && !hostWrite && mappingEnableFlag)
    else $error("read data driven outside a good read");
  mem_hold_a: assert property (memReq_r && !memGnt |=>
    memReq_r && $stable(memAddr_r) && $stable(memWrite_r))
    else $error("memory request dropped or changed");
  gnt_release_a: assert property (memReq_r && memGnt |=> !memReq_r)
    else $error("request still up after grant");
  rt_class_a: assert property (memReq_r |->
    memRealTime_r == (memPriority_r >= 2'h2))
    else $error("real time class wrong");
  pix_hold_a: assert property (pixValid_r && !pixReady |=>
    pixValid_r && $stable(pixAddr_r))
    else $error("pixel address not held");
  buf_hold_a: assert property (outValid && !outReady |=>
    outValid && $stable(outData))
    else $error("output word lost under stall");
  in_pace_a: assert property (inValid && inReady_r |=> !inReady_r)
    else $error("input ready not dropped after a word");
  cmd_pulse_a: assert property (cmdReady_r |=> !cmdReady_r)
    else $error("command ready longer than one cycle");
  cover property (hostAck_r && !hostRdataOe_n_r);
  cover property (outValid && outReady);
  cover property (pixValid_r && pixReady);
  cover property (memReq_r && memGnt && memWrite_r);
endmodule
bind video_ram_physical_access vram_access_chk #(.AW(AW), .DW(DW)) uChk (
  .clock, .rst_n, .mappingEnableFlag, .hostReq, .hostWrite, .hostAck_r,
  .hostRdataOe_n_r, .cmdReady_r, .inValid, .inReady_r, .outValid,
  .outData, .outReady, .pixValid_r, .pixAddr_r, .pixReady, .memReq_r,
  .memWrite_r, .memAddr_r, .memPriority_r, .memRealTime_r, .memGnt,
  .memRowHit_r, .directAccessReady_r
);
